// ---- hdl/cie_params.svh ----
`ifndef CIE_PARAMS_SVH
`define CIE_PARAMS_SVH

// =====================================================
// register map, byte addresses on the bus
`define CIE_ADDR_SSR 8'h00
`define CIE_ADDR_IVR 8'h04
`define CIE_ADDR_LMASK 8'h08
`define CIE_ADDR_LFLAG 8'h0C
`define CIE_ADDR_EVT 8'h10
`define CIE_ADDR_EVT_MASK 8'h14

// =====================================================
// field positions and reset values
`define CIE_SSR_PEND_BIT 0
`define CIE_SSR_GMASK_BIT 1
`define CIE_SSR_DEPTH_LSB 4
`define CIE_EVT_LVL_BIT 0
`define CIE_EVT_NMI_BIT 1
`define CIE_EVT_PHANTOM_BIT 2
`define CIE_EVT_OVF_BIT 3
`define CIE_GMASK_RESET 1'b1
`define CIE_LMASK_RESET 6'h00

// =====================================================
// vectors, dispatch timing and bus response codes
`define CIE_VEC_NMI 16'h0024
`define CIE_PHANTOM 16'h0000
`define CIE_N_PERIPH 2'd2
`define CIE_N_EVM 2'd1
`define CIE_ACK_WAIT 4
`define CIE_RESP_OKAY 2'b00
`define CIE_RESP_SLVERR 2'b10
`endif

// ---- hdl/cie_pkg.sv ----
package cie_pkg;
	// kind of the instruction retiring this cycle
	typedef struct packed {
		logic call;
		logic ret;
		logic unmask;
		logic mask;
	} cie_instr_t;

	// vector offset load from the peripheral side
	typedef struct packed {
		logic valid;
		logic src_evm;
		logic [15:0] offset;
	} cie_ivr_load_t;

	// read channel sequencer
	typedef enum logic [2:0] {
		CIE_RD_IDLE = 3'b001,
		CIE_RD_WAIT = 3'b010,
		CIE_RD_RESP = 3'b100
	} cie_rd_state_t;
endpackage

// ---- hdl/cie_ret_stack.sv ----
`include "cie_params.svh"
module cie_ret_stack #(
	parameter int DEPTH = 8,
	parameter int AW = 16
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic nrst_i,
	// stack operations
	input wire logic push_i,
	input wire logic pop_i,
	input wire logic [AW-1:0] data_i,
	input wire logic debug_active_i,
	// state
	output logic [AW-1:0] top_o,
	output logic [3:0] count_o,
	output logic ovf_o
);
	import cie_pkg::*;
	logic [AW-1:0] mem_r [DEPTH];
	logic [3:0] count_r;
	logic [3:0] limit;

	// debug reserves one level while active
	assign limit = debug_active_i ? 4'(DEPTH - 1) : 4'(DEPTH);
	assign top_o = mem_r[0];
	assign count_o = count_r;
	assign ovf_o = push_i && !pop_i && (count_r >= limit);

	// =====================================================
	// entry shift: oldest falls off the far end, so no stall
	genvar i;
	generate
		for (i = 0; i < DEPTH; i++) begin : g_ent
			always_ff @(posedge clock_i) begin
				if (!nrst_i) begin
					mem_r[i] <= '0;
				end else if (push_i && pop_i) begin
					if (i == 0) mem_r[i] <= data_i;
				end else if (push_i) begin
					mem_r[i] <= (i == 0) ? data_i : mem_r[(i == 0) ? 0 : i - 1];
				end else if (pop_i) begin
					mem_r[i] <= (i == DEPTH - 1) ? '0 : mem_r[(i == DEPTH - 1) ? i : i + 1];
				end
			end
		end
	endgenerate

	// occupancy saturates at the limit
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			count_r <= 4'h0;
		end else if (push_i && !pop_i) begin
			if (count_r < limit) count_r <= count_r + 4'h1;
		end else if (pop_i && !push_i) begin
			if (count_r != 4'h0) count_r <= count_r - 4'h1;
		end
	end

	a_stack_full_keep: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(push_i && !pop_i && count_r == limit) |=> (count_r == $past(count_r)))
		else $error("full stack push changed occupancy");
	a_stack_pop_count: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(pop_i && !push_i && count_r != 4'h0) |=> (count_r == $past(count_r) - 4'h1))
		else $error("pop did not lower occupancy");
	a_stack_push_top: assert property (@(posedge clock_i) disable iff (!nrst_i)
		push_i |=> (mem_r[0] == $past(data_i)))
		else $error("pushed address not on top");
endmodule

// ---- hdl/cie_core_irq.sv ----
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`include "cie_params.svh"
module cie_core_irq #(
	parameter int ACK_WAIT = `CIE_ACK_WAIT,
	parameter int STACK_DEPTH = 8
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic nrst_i,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [7:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// requests from the peripheral side
	input wire logic [5:0] lvl_req_i,
	input wire logic nmi_req_i,
	input wire cie_pkg::cie_ivr_load_t ivr_load_i,
	// instruction stream
	input wire logic retire_i,
	input wire cie_pkg::cie_instr_t instr_i,
	input wire logic [15:0] pc_inc_i,
	input wire logic debug_active_i,
	// answers to the core
	output logic take_o,
	output logic [15:0] vector_addr_o,
	output logic ret_valid_o,
	output logic [15:0] ret_addr_o,
	output logic global_irq_mask_o,
	output logic dispatch_stall_o,
	output logic irq_o
);
	import cie_pkg::*;

	// lowest numbered pending level wins; 0 means none
	function automatic logic [2:0] cie_first_level(input logic [5:0] hit);
		logic [2:0] n;
		n = 3'd0;
		for (int k = 5; k >= 0; k--) begin
			if (hit[k]) n = 3'(k + 1);
		end
		return n;
	endfunction

	// =====================================================
	// state
	logic [5:0] level_flag_reg_r;
	logic [5:0] level_mask_reg_r;
	logic global_irq_mask_r;
	logic nmi_pend_r;
	logic blocked_r;
	logic [15:0] vector_offset_reg_r;
	logic ivr_src_evm_r;
	logic vector_read_pending_r;
	logic [3:0] evt_r;
	logic [3:0] evt_mask_r;
	logic [7:0] ph_cnt_r;
	logic take_r;
	logic [15:0] vec_r;
	logic ret_valid_r;
	logic [15:0] ret_addr_r;
	logic irq_r;

	// =====================================================
	// take decision at an instruction boundary
	logic take_ok;
	logic take_nmi;
	logic take_lvl;
	logic [5:0] lvl_hit;
	logic [2:0] lvl_num;
	logic do_push;
	logic do_pop;
	logic [15:0] stk_top;
	logic [3:0] stk_count;
	logic stk_ovf;
	logic phantom;

	// unmask, return and call retirements never host an entry
	assign take_ok = retire_i && !blocked_r && !instr_i.unmask && !instr_i.ret && !instr_i.call;
	assign lvl_hit = level_flag_reg_r & level_mask_reg_r & {6{!global_irq_mask_r}};
	assign lvl_num = cie_first_level(lvl_hit);
	assign take_nmi = take_ok && nmi_pend_r;
	assign take_lvl = take_ok && !nmi_pend_r && (lvl_num != 3'd0);
	assign do_push = take_nmi || take_lvl || (retire_i && instr_i.call);
	assign do_pop = retire_i && instr_i.ret;
	assign phantom = (ph_cnt_r == 8'd1) && !ivr_load_i.valid;

	// one-instruction shadow after unmask or return
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			blocked_r <= 1'b0;
		end else if (retire_i) begin
			blocked_r <= instr_i.unmask || instr_i.ret;
		end
	end

	// global mask: set by every entry, cleared only by the unmask instruction
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			global_irq_mask_r <= `CIE_GMASK_RESET;
		end else if (take_nmi || take_lvl || (retire_i && instr_i.mask)) begin
			global_irq_mask_r <= 1'b1;
		end else if (retire_i && instr_i.unmask) begin
			global_irq_mask_r <= 1'b0;
		end
	end

	// nmi latch; a new request in the take cycle is kept
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			nmi_pend_r <= 1'b0;
		end else begin
			nmi_pend_r <= (nmi_pend_r && !take_nmi) || nmi_req_i;
		end
	end

	// entry outputs; only pc_inc goes to the stack
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			take_r <= 1'b0;
			vec_r <= 16'h0000;
			ret_valid_r <= 1'b0;
			ret_addr_r <= 16'h0000;
		end else begin
			take_r <= take_nmi || take_lvl;
			if (take_nmi) vec_r <= `CIE_VEC_NMI;
			else if (take_lvl) vec_r <= {12'h000, lvl_num, 1'b0};
			ret_valid_r <= do_pop;
			if (do_pop) ret_addr_r <= stk_top;
		end
	end

	cie_ret_stack #(.DEPTH(STACK_DEPTH), .AW(16)) u_stack (
		.clock_i(clock_i),
		.nrst_i(nrst_i),
		.push_i(do_push),
		.pop_i(do_pop),
		.data_i(pc_inc_i),
		.debug_active_i(debug_active_i),
		.top_o(stk_top),
		.count_o(stk_count),
		.ovf_o(stk_ovf)
	);

	// =====================================================
	// axi4-lite slave
	logic aw_free_r;
	logic w_free_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	cie_rd_state_t rd_state_r;
	logic [1:0] rd_cnt_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic ar_hs;
	logic wr_go;
	logic rd_ivr;
	logic rd_evt;
	logic [5:0] flag_w1c;

	assign ar_hs = s_axi_arvalid_i && (rd_state_r == CIE_RD_IDLE);
	assign wr_go = !aw_free_r && !w_free_r && !bvalid_r;
	assign rd_ivr = ar_hs && (s_axi_araddr_i == `CIE_ADDR_IVR);
	assign rd_evt = ar_hs && (s_axi_araddr_i == `CIE_ADDR_EVT);
	assign flag_w1c = (wr_go && aw_addr_r == `CIE_ADDR_LFLAG && w_strb_r[0]) ? w_data_r[5:0] : 6'h00;

	// address and data are taken in either order, write once both are held
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			aw_free_r <= 1'b1;
			w_free_r <= 1'b1;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= `CIE_RESP_OKAY;
		end else begin
			if (aw_free_r && s_axi_awvalid_i) begin
				aw_free_r <= 1'b0;
				aw_addr_r <= s_axi_awaddr_i;
			end
			if (w_free_r && s_axi_wvalid_i) begin
				w_free_r <= 1'b0;
				w_data_r <= s_axi_wdata_i;
				w_strb_r <= s_axi_wstrb_i;
			end
			if (wr_go) begin
				aw_free_r <= 1'b1;
				w_free_r <= 1'b1;
				bvalid_r <= 1'b1;
				if (aw_addr_r == `CIE_ADDR_LMASK || aw_addr_r == `CIE_ADDR_LFLAG ||
					aw_addr_r == `CIE_ADDR_EVT_MASK) begin
					bresp_r <= `CIE_RESP_OKAY;
				end else if (aw_addr_r == `CIE_ADDR_SSR || aw_addr_r == `CIE_ADDR_IVR ||
					aw_addr_r == `CIE_ADDR_EVT) begin
					bresp_r <= `CIE_RESP_OKAY; // read-only: write ignored
				end else begin
					bresp_r <= `CIE_RESP_SLVERR;
				end
			end else if (bvalid_r && s_axi_bready_i) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// writable control registers, low byte lane only
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			level_mask_reg_r <= `CIE_LMASK_RESET;
			evt_mask_r <= 4'h0;
		end else if (wr_go && w_strb_r[0]) begin
			if (aw_addr_r == `CIE_ADDR_LMASK) level_mask_reg_r <= w_data_r[5:0];
			else if (aw_addr_r == `CIE_ADDR_EVT_MASK) evt_mask_r <= w_data_r[3:0];
		end
	end

	// read sequencer; an offset read stalls dispatch n cycles
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			rd_state_r <= CIE_RD_IDLE;
			rd_cnt_r <= 2'd0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= `CIE_RESP_OKAY;
		end else begin
			case (rd_state_r)
				CIE_RD_IDLE: begin
					if (ar_hs) begin
						rresp_r <= `CIE_RESP_OKAY;
						rdata_r <= 32'h0000_0000;
						if (s_axi_araddr_i == `CIE_ADDR_SSR) begin
							rdata_r[`CIE_SSR_PEND_BIT] <= vector_read_pending_r;
							rdata_r[`CIE_SSR_GMASK_BIT] <= global_irq_mask_r;
							rdata_r[`CIE_SSR_DEPTH_LSB +: 4] <= stk_count;
						end else if (s_axi_araddr_i == `CIE_ADDR_IVR) begin
							rdata_r[15:0] <= vector_offset_reg_r;
						end else if (s_axi_araddr_i == `CIE_ADDR_LMASK) begin
							rdata_r[5:0] <= level_mask_reg_r;
						end else if (s_axi_araddr_i == `CIE_ADDR_LFLAG) begin
							rdata_r[5:0] <= level_flag_reg_r;
						end else if (s_axi_araddr_i == `CIE_ADDR_EVT) begin
							rdata_r[3:0] <= evt_r;
						end else if (s_axi_araddr_i == `CIE_ADDR_EVT_MASK) begin
							rdata_r[3:0] <= evt_mask_r;
						end else begin
							rresp_r <= `CIE_RESP_SLVERR;
						end
						if (rd_ivr) begin
							rd_cnt_r <= ivr_src_evm_r ? `CIE_N_EVM : `CIE_N_PERIPH;
							rd_state_r <= CIE_RD_WAIT;
						end else begin
							rd_state_r <= CIE_RD_RESP;
						end
					end
				end
				CIE_RD_WAIT: begin
					rd_cnt_r <= rd_cnt_r - 2'd1;
					if (rd_cnt_r == 2'd1) rd_state_r <= CIE_RD_RESP;
				end
				CIE_RD_RESP: begin
					if (s_axi_rready_i) rd_state_r <= CIE_RD_IDLE;
				end
				default: rd_state_r <= CIE_RD_IDLE;
			endcase
		end
	end

	// =====================================================
	// level flags: a new request beats the acknowledge and software clears
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			level_flag_reg_r <= 6'h00;
		end else begin
			level_flag_reg_r <= (level_flag_reg_r & ~flag_w1c &
				~(take_lvl ? 6'(1 << (lvl_num - 3'd1)) : 6'h00)) | lvl_req_i;
		end
	end

	// phantom watchdog, armed by maskable entries only, so nmi leaves the offset alone
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			ph_cnt_r <= 8'd0;
		end else if (take_lvl) begin
			ph_cnt_r <= 8'(ACK_WAIT);
		end else if (ivr_load_i.valid) begin
			ph_cnt_r <= 8'd0;
		end else if (ph_cnt_r != 8'd0) begin
			ph_cnt_r <= ph_cnt_r - 8'd1;
		end
	end

	// offset register: last load wins; load beats a read in the same cycle
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			vector_offset_reg_r <= `CIE_PHANTOM;
			ivr_src_evm_r <= 1'b0;
			vector_read_pending_r <= 1'b0;
		end else begin
			if (ivr_load_i.valid) begin
				vector_offset_reg_r <= ivr_load_i.offset;
				ivr_src_evm_r <= ivr_load_i.src_evm;
			end else if (phantom) begin
				vector_offset_reg_r <= `CIE_PHANTOM;
				ivr_src_evm_r <= 1'b0;
			end
			vector_read_pending_r <= (vector_read_pending_r && !rd_ivr) ||
				ivr_load_i.valid || phantom;
		end
	end

	// sticky events cleared by reading them, new events win; interrupt level out
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			evt_r <= 4'h0;
			irq_r <= 1'b0;
		end else begin
			evt_r <= (rd_evt ? 4'h0 : evt_r) | {stk_ovf, phantom, take_nmi, take_lvl};
			irq_r <= |(evt_r & evt_mask_r);
		end
	end

	// =====================================================
	// outputs
	assign s_axi_awready_o = aw_free_r;
	assign s_axi_wready_o = w_free_r;
	assign s_axi_bvalid_o = bvalid_r;
	assign s_axi_bresp_o = bresp_r;
	assign s_axi_arready_o = rd_state_r[0];
	assign s_axi_rvalid_o = rd_state_r[2];
	assign s_axi_rdata_o = rdata_r;
	assign s_axi_rresp_o = rresp_r;
	assign take_o = take_r;
	assign vector_addr_o = vec_r;
	assign ret_valid_o = ret_valid_r;
	assign ret_addr_o = ret_addr_r;
	assign global_irq_mask_o = global_irq_mask_r;
	assign dispatch_stall_o = rd_state_r[1];
	assign irq_o = irq_r;

	// =====================================================
	// checks
	a_nmi_vector_fixed: assert property (@(posedge clock_i) disable iff (!nrst_i)
		take_nmi |=> (take_o && vector_addr_o == `CIE_VEC_NMI))
		else $error("nmi entry not at its fixed vector");
	a_level_vector_slot: assert property (@(posedge clock_i) disable iff (!nrst_i)
		take_lvl |=> (take_o && vector_addr_o == {12'h000, $past(lvl_num), 1'b0}))
		else $error("level entry at wrong slot");
	a_nmi_keeps_offset: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(take_nmi && !ivr_load_i.valid && ph_cnt_r == 8'd0) |=>
		$stable(vector_offset_reg_r))
		else $error("nmi disturbed the vector offset");
	a_pend_on_load: assert property (@(posedge clock_i) disable iff (!nrst_i)
		ivr_load_i.valid |=> (vector_read_pending_r &&
		vector_offset_reg_r == $past(ivr_load_i.offset)))
		else $error("offset load did not set pending");
	a_ack_sets_mask: assert property (@(posedge clock_i) disable iff (!nrst_i)
		take_lvl |=> (global_irq_mask_r && take_o))
		else $error("acknowledge left global mask clear");
	a_unmask_shadow: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(retire_i && instr_i.unmask) |=> (blocked_r && !take_nmi && !take_lvl))
		else $error("entry inside unmask shadow");
	a_ret_shadow: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(retire_i && instr_i.ret) |-> (!do_push ##1 (blocked_r && !take_nmi && !take_lvl)))
		else $error("push alongside or right after a return");
	a_ivr_stall_periph: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(rd_ivr && !ivr_src_evm_r) |=> dispatch_stall_o ##1 dispatch_stall_o ##1
		(!dispatch_stall_o && s_axi_rvalid_o))
		else $error("peripheral offset read not two extra cycles");
	a_ivr_stall_evm: assert property (@(posedge clock_i) disable iff (!nrst_i)
		(rd_ivr && ivr_src_evm_r) |=> dispatch_stall_o ##1
		(!dispatch_stall_o && s_axi_rvalid_o))
		else $error("event manager offset read not one extra cycle");
	a_phantom_value: assert property (@(posedge clock_i) disable iff (!nrst_i)
		phantom |=> (vector_offset_reg_r == `CIE_PHANTOM && vector_read_pending_r))
		else $error("phantom offset not loaded");
	a_mask_gates_take: assert property (@(posedge clock_i) disable iff (!nrst_i)
		take_lvl |-> (!global_irq_mask_r && level_mask_reg_r[lvl_num - 3'd1]))
		else $error("level taken while masked");
endmodule

// ---- verif/cie_periph_model.sv ----
`include "cie_params.svh"
module cie_periph_model (
	// clock and reset
	input wire logic clock_i,
	input wire logic nrst_i,
	// entry seen at the core
	input wire logic take_i,
	input wire logic [15:0] vector_i,
	// bench commands
	input wire logic ld_en_i,
	input wire logic ld_evm_i,
	input wire logic [15:0] ld_off_i,
	input wire logic [1:0] ld_dly_i,
	// offset load towards the core
	output cie_pkg::cie_ivr_load_t ivr_load_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import cie_pkg::*;
	logic [2:0] cnt_r;
	logic [15:0] last_r;
	// =====================================================
	// offset answer
	// answer a level entry after the commanded delay; nmi entries get no load
	always_ff @(posedge clock_i) begin
		if (!nrst_i) begin
			cnt_r <= 3'd0;
			last_r <= 16'h0000;
			ivr_load_o <= '0;
		end else begin
			ivr_load_o.valid <= 1'b0;
			ivr_load_o.src_evm <= ~ld_evm_i;
			ivr_load_o.offset <= ~last_r; // released bus must not look like the last value
			if (take_i && ld_en_i && vector_i != `CIE_VEC_NMI) begin
				cnt_r <= {1'b0, ld_dly_i} + 3'd1;
			end else if (cnt_r != 3'd0) begin
				cnt_r <= cnt_r - 3'd1;
			end
			if (cnt_r == 3'd1) begin
				ivr_load_o.valid <= 1'b1;
				ivr_load_o.src_evm <= ld_evm_i; // source decides the read delay
				ivr_load_o.offset <= ld_off_i;
				last_r <= ld_off_i;
			end
		end
	end
endmodule

// ---- verif/cie_core_irq_tb_top.sv ----
`include "cie_params.svh"
module cie_core_irq_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import cie_pkg::*;
	localparam cie_instr_t NOP = 4'h0;
	localparam cie_instr_t CAL = 4'h8;
	localparam cie_instr_t RET = 4'h4;
	localparam cie_instr_t UNM = 4'h2;
	logic clk, nrst, awvalid, wvalid, bready, arvalid, rready, nmi, retire, dbg;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	logic awready, wready, bvalid, arready, rvalid, take, ret_valid, gmask, stall, irq;
	logic [15:0] vec, raddr_o, pc_inc, ld_off, tvec, raddr;
	logic [5:0] lvl;
	logic ld_en, ld_evm;
	logic [1:0] ld_dly;
	cie_instr_t instr;
	cie_ivr_load_t ivr_load;
	int error_cnt, n_tests, took, stalls;
	// =====================================================
	// design and partner
	cie_core_irq dut (.clock_i(clk), .nrst_i(nrst), .s_axi_awaddr_i(awaddr),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .lvl_req_i(lvl), .nmi_req_i(nmi), .ivr_load_i(ivr_load),
		.retire_i(retire), .instr_i(instr), .pc_inc_i(pc_inc), .debug_active_i(dbg),
		.take_o(take), .vector_addr_o(vec), .ret_valid_o(ret_valid), .ret_addr_o(raddr_o),
		.global_irq_mask_o(gmask), .dispatch_stall_o(stall), .irq_o(irq));
	cie_periph_model u_periph (.clock_i(clk), .nrst_i(nrst), .take_i(take), .vector_i(vec),
		.ld_en_i(ld_en), .ld_evm_i(ld_evm), .ld_off_i(ld_off), .ld_dly_i(ld_dly),
		.ivr_load_o(ivr_load));
	// =====================================================
	// clock, entry monitor, watchdog
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// entries and pops are pulses, so catch them wherever they land
	always @(posedge clk) begin
		if (take === 1'b1) begin
			took <= took + 1;
			tvec <= vec;
		end
		if (ret_valid === 1'b1) raddr <= raddr_o;
	end
	// the whole sequence needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		final_report();
	end
	// =====================================================
	// tasks
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic final_report();
		if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// an edge between calls, so a ready line is never dropped and raised in one step
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk("bresp", 32'(bresp), 32'(er));
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		@(posedge clk);
		stalls = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (stall === 1'b1) stalls++;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk("rresp", 32'(rresp), 32'(er));
		chk("rdata", rdata, exp);
	endtask
	task automatic step(input cie_instr_t k, input logic [15:0] pc);
		@(posedge clk);
		retire <= 1'b1;
		instr <= k;
		pc_inc <= pc;
		@(posedge clk);
		retire <= 1'b0;
		instr <= NOP;
		repeat (2) @(posedge clk);
	endtask
	task automatic req(input logic [5:0] l, input logic n);
		@(posedge clk);
		lvl <= l;
		nmi <= n;
		@(posedge clk);
		lvl <= 6'h00;
		nmi <= 1'b0;
	endtask
	// unmask, one blocked retire, then the entry itself
	task automatic entry(input logic [15:0] pc, input logic [15:0] ev);
		int t0;
		t0 = took;
		step(UNM, 16'h0000);
		step(NOP, 16'h0000);
		chk("blocked", 32'(took), 32'(t0));
		step(NOP, pc);
		chk("take", 32'(took), 32'(t0 + 1));
		chk("vector", 32'(tvec), 32'(ev));
		repeat (8) @(posedge clk);
	endtask
	// =====================================================
	// tests
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, nmi, retire, dbg, ld_en, ld_evm} = '0;
		{awaddr, araddr, wdata, pc_inc, ld_off, ld_dly, lvl} = '0;
		instr = NOP;
		{error_cnt, n_tests, took, stalls} = '0;
		nrst = 1'b0;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		rd(8'h00, 32'h0000_0002, `CIE_RESP_OKAY);
		rd(8'h18, 32'h0000_0000, `CIE_RESP_SLVERR);
		wr(8'h18, 32'h0000_0001, `CIE_RESP_SLVERR);
		// level one masked at its level bit: never taken
		wr(8'h08, 32'h0000_003E, `CIE_RESP_OKAY);
		req(6'h01, 1'b0);
		step(UNM, 16'h0000);
		step(NOP, 16'h0000);
		step(NOP, 16'h0000);
		chk("masked", 32'(took), 32'd0);
		chk("gmask", 32'(gmask), 32'd0);
		rd(8'h0C, 32'h0000_0001, `CIE_RESP_OKAY);
		wr(8'h0C, 32'h0000_0001, `CIE_RESP_OKAY);
		wr(8'h08, 32'h0000_003F, `CIE_RESP_OKAY);
		ld_en <= 1'b1;
		// every level once, sources alternating, answer delay taken from bit 1 of the level number
		for (int k = 1; k <= 6; k++) begin
			ld_evm <= k[0];
			ld_dly <= {1'b0, k[1]};
			ld_off <= 16'h0010 + 16'(k);
			req(6'(1 << (k - 1)), 1'b0);
			entry(16'h0200 + 16'(k), 16'(2 * k));
			chk("gmask", 32'(gmask), 32'd1);
			rd(8'h00, 32'h0000_0013, `CIE_RESP_OKAY);
			rd(8'h04, 32'h0000_0010 + k, `CIE_RESP_OKAY);
			chk("stall", 32'(stalls), k[0] ? 32'd1 : 32'd2);
			rd(8'h00, 32'h0000_0012, `CIE_RESP_OKAY);
			rd(8'h0C, 32'h0000_0000, `CIE_RESP_OKAY);
			step(RET, 16'h0000);
			chk("pop", 32'(raddr), 32'h0000_0200 + k);
		end
		// nmi leaves an unread offset alone, a later level overwrites it
		ld_evm <= 1'b0;
		ld_off <= 16'h0031;
		req(6'h02, 1'b0);
		entry(16'h0300, 16'h0004);
		req(6'h00, 1'b1);
		step(NOP, 16'h0301);
		chk("nmi", 32'(tvec), 32'h0000_0024);
		repeat (8) @(posedge clk);
		rd(8'h00, 32'h0000_0023, `CIE_RESP_OKAY);
		step(RET, 16'h0000);
		ld_off <= 16'h0032;
		req(6'h04, 1'b0);
		entry(16'h0302, 16'h0006);
		rd(8'h04, 32'h0000_0032, `CIE_RESP_OKAY);
		step(RET, 16'h0000);
		step(RET, 16'h0000);
		chk("pop", 32'(raddr), 32'h0000_0300);
		// a return right after unmask pops before the pending level enters
		req(6'h08, 1'b0);
		step(CAL, 16'h0400);
		step(UNM, 16'h0000);
		step(RET, 16'h0000);
		chk("pop", 32'(raddr), 32'h0000_0400);
		step(NOP, 16'h0000);
		chk("blocked", 32'(took), 32'd9);
		step(NOP, 16'h0401);
		chk("vector", 32'(tvec), 32'h0000_0008);
		repeat (8) @(posedge clk);
		rd(8'h00, 32'h0000_0013, `CIE_RESP_OKAY);
		rd(8'h04, 32'h0000_0032, `CIE_RESP_OKAY);
		step(RET, 16'h0000);
		// no offset answer: phantom value after the wait
		ld_en <= 1'b0;
		req(6'h10, 1'b0);
		entry(16'h0500, 16'h000A);
		rd(8'h00, 32'h0000_0013, `CIE_RESP_OKAY);
		rd(8'h04, 32'h0000_0000, `CIE_RESP_OKAY);
		chk("stall", 32'(stalls), 32'd2);
		step(RET, 16'h0000);
		// event status and interrupt line
		chk("irq", 32'(irq), 32'd0);
		wr(8'h14, 32'h0000_000F, `CIE_RESP_OKAY);
		repeat (3) @(posedge clk);
		chk("irq", 32'(irq), 32'd1);
		rd(8'h10, 32'h0000_0007, `CIE_RESP_OKAY);
		repeat (3) @(posedge clk);
		chk("irq", 32'(irq), 32'd0);
		// nine pushes into a full stack, with and without debug reservation
		for (int d = 0; d <= 1; d++) begin
			dbg <= d[0];
			for (int i = 1; i <= 9; i++) step(CAL, 16'h0600 + 16'(i));
			rd(8'h00, 32'h0000_0002 + ((8 - d) << 4), `CIE_RESP_OKAY);
			for (int j = 0; j < 8 - d; j++) begin
				step(RET, 16'h0000);
				chk("pop", 32'(raddr), 32'h0000_0609 - j);
			end
		end
		rd(8'h10, 32'h0000_0008, `CIE_RESP_OKAY);
		final_report();
	end
endmodule
